// *** bench/lpw_cpu_model.sv ***
// CPU core and interrupt source model
`timescale 1ns/100ps
module lpw_cpu_model (
    input wire logic clk_i,
    input wire logic wait_cmd_i,
    input wire logic nmi_cmd_i,
    input wire logic prio_on_i,
    input wire logic [63:0] src_i,
    input wire logic [2:0] pin_low_i,
    output logic wait_exec_o,
    output logic nmi_o,
    output logic [63:0] periph_irq_o,
    output logic [2:0] ext_pin_o
);
    always @(posedge clk_i) begin
        wait_exec_o <= wait_cmd_i;
        nmi_o <= nmi_cmd_i;
    end
    assign periph_irq_o = prio_on_i ? src_i : 64'h0;
    assign ext_pin_o = ~pin_low_i; // Pulled-up pins idle high
endmodule : lpw_cpu_model

// *** bench/lpw_monitor.sv ***
// Assertion checker on the wake controller ports
`timescale 1ns/100ps
module lpw_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wait_exec_i,
    input wire logic nmi_i,
    input wire logic cpu_clk_en_o,
    input wire logic [1:0] cpu_clk_sel_o,
    input wire logic periph_clk_en_o,
    input wire logic converter_clk_en_o,
    input wire logic indep_clk_en_o,
    input wire logic protected_clk_en_o,
    input wire logic [2:0] power_state_o,
    input wire logic irq_o
);
    import lpw_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle after request");
    a_wait_entry: assert property (power_state_o == PM_RUN && wait_exec_i && !wb_cyc_i |=>
        power_state_o == PM_WAIT && !cpu_clk_en_o) else $error("wait not entered");
    a_nmi_wake: assert property (power_state_o == PM_WAIT && nmi_i |=> power_state_o == PM_RUN)
        else $error("nmi did not end wait");
    a_cpu_gate: assert property (cpu_clk_en_o == (power_state_o == PM_RUN))
        else $error("cpu clock enable wrong for mode");
    a_stop_halt: assert property (power_state_o == PM_STOP |-> !periph_clk_en_o && !indep_clk_en_o)
        else $error("clock running in stop");
    a_prot_clock: assert property (protected_clk_en_o)
        else $error("protected clock halted");
    a_conv_follow: assert property (converter_clk_en_o == periph_clk_en_o)
        else $error("converter clock differs from peripheral clock");
    a_indep_run: assert property (power_state_o != PM_STOP |-> indep_clk_en_o)
        else $error("independent clock halted outside stop");
    a_sel_held: assert property (power_state_o != PM_RUN ##1 power_state_o != PM_RUN |-> $stable(cpu_clk_sel_o))
        else $error("clock select moved while halted");
    a_mode_onehot: assert property ($onehot(power_state_o))
        else $error("power state not one-hot");
    c_wait_exit: cover property (power_state_o == PM_WAIT ##1 power_state_o == PM_RUN);
    c_stop_seen: cover property (power_state_o == PM_STOP);
    c_irq_seen: cover property ($rose(irq_o));
endmodule : lpw_monitor

// *** bench/testbench.sv ***
// Self-checking bench for the wake controller
`timescale 1ns/100ps
module testbench;
    import lpw_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} lpw_row_t;
    logic clk_i = '0, rst_i = 1'h1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, wc = '0, nc = '0, pon = 1'h1;
    logic lvd_event_i = '0, wb_ack_o, wait_exec_i, nmi_i, cpu_clk_en_o, periph_clk_en_o, converter_clk_en_o;
    logic indep_clk_en_o, protected_clk_en_o, lvd_active_o, irq_o;
    logic [7:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, rdat, wb_dat_o;
    logic [1:0] cpu_clk_sel_i = 2'h1, cpu_clk_sel_o;
    logic [63:0] src = '0, periph_irq_i;
    logic [2:0] plow = '0, ext_int_pin_i, pst;
    int failures = 0, checks = 0;
    lpw_row_t rows [10] = '{'{1'h1, OFS_CTRL, 32'h72}, '{1'h0, OFS_CTRL, 32'h72}, '{1'h0, OFS_IIO0, 32'h1},
        '{1'h0, OFS_IIO1, 32'h1}, '{1'h0, OFS_IIO2, 32'h1}, '{1'h1, OFS_IRQ_EN, 32'h7}, '{1'h0, OFS_IRQ_EN, 32'h7},
        '{1'h0, OFS_STATE, 32'h19}, '{1'h1, 8'h40, 32'hFF}, '{1'h0, 8'h40, 32'h0}};
    always #20 clk_i = ~clk_i;
    lpw_wake_ctrl #(.LVD_CYC(4)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o, .wait_exec_i, .cpu_clk_sel_i, .nmi_i, .lvd_event_i, .periph_irq_i,
        .periph_indep_clk_i(64'h40), .ext_int_pin_i, .cpu_clk_en_o, .cpu_clk_sel_o, .periph_clk_en_o,
        .converter_clk_en_o, .indep_clk_en_o, .protected_clk_en_o, .lvd_active_o, .power_state_o(pst), .irq_o);
    lpw_cpu_model i_cpu (.clk_i, .wait_cmd_i(wc), .nmi_cmd_i(nc), .prio_on_i(pon), .src_i(src), .pin_low_i(plow),
        .wait_exec_o(wait_exec_i), .nmi_o(nmi_i), .periph_irq_o(periph_irq_i), .ext_pin_o(ext_int_pin_i));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic go_wait;
        @(posedge clk_i);
        wc <= 1'h1;
        @(posedge clk_i);
        wc <= 1'h0;
        tick(2);
    endtask : go_wait
    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    initial begin
        #100us;
        failures++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk($sformatf("reg %h", rows[i].a), rows[i].d, rdat);
        end
        $display("register table done");
        go_wait();
        chk("wait state", 32'h2, pst);
        chk("periph clk", 32'h1, periph_clk_en_o);
        @(posedge clk_i);
        cpu_clk_sel_i <= 2'h2;
        @(posedge clk_i);
        nc <= 1'h1;
        tick(3);
        chk("nmi wake", 32'h1, pst);
        chk("held sel", 32'h1, cpu_clk_sel_o);
        nc <= 1'h0;
        wb(1'h0, OFS_IRQ_STAT, '0);
        chk("wait flag", 32'h1, rdat);
        wb(1'h1, OFS_IRQ_EN, '0);
        tick(2);
        chk("irq masked", 32'h0, irq_o);
        wb(1'h1, OFS_IRQ_EN, 32'h7);
        tick(2);
        chk("irq raised", 32'h1, irq_o);
        wb(1'h1, OFS_IRQ_CLR, 32'h7);
        tick(2);
        chk("irq cleared", 32'h0, irq_o);
        $display("nmi wake done");
        {pon, src} <= {1'h0, 64'h8000000000000000};
        go_wait();
        tick(3);
        chk("masked src", 32'h2, pst);
        pon <= 1'h1;
        tick(3);
        chk("src 63 wake", 32'h1, pst);
        wb(1'h1, OFS_CTRL, 32'h73);
        src <= 64'h20;
        go_wait();
        chk("conv clk", 32'h0, converter_clk_en_o);
        tick(3);
        chk("halted src", 32'h2, pst);
        src <= 64'h60;
        tick(2);
        chk("indep src", 32'h1, pst);
        src <= '0;
        $display("peripheral wake done");
        chk("lvd on", 32'h1, lvd_active_o);
        wb(1'h1, OFS_CTRL, 32'h76);
        tick(2);
        chk("stop", 32'h4, pst);
        lvd_event_i <= 1'h1;
        tick(5);
        chk("lvd wake", 32'h1, pst);
        lvd_event_i <= 1'h0;
        $display("stop wake done");
        plow <= 3'h1;
        tick(8);
        wb(1'h0, OFS_IIO0, '0);
        chk("flag six", 32'h3, rdat);
        wb(1'h1, OFS_IIO0, '0);
        plow <= 3'h0;
        tick(8);
        wb(1'h0, OFS_IIO0, '0);
        chk("rise ignored", 32'h1, rdat);
        go_wait();
        plow <= 3'h2;
        tick(8);
        chk("pin wake", 32'h1, pst);
        plow <= 3'h0;
        $display("pin flag done");
        wb(1'h1, OFS_CTRL, 32'h6);
        tick(2);
        chk("stop held", 32'h4, pst);
        rst_i <= 1'h1;
        tick(2);
        rst_i <= 1'h0;
        chk("reset mode", 32'h1, pst);
        chk("reset cpu clk", 32'h1, cpu_clk_en_o);
        wb(1'h0, OFS_CTRL, '0);
        chk("reset ctrl", 32'h0, rdat);
        $display("reset done");
        summarize();
    end
endmodule : testbench
bind lpw_wake_ctrl lpw_monitor i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wait_exec_i, .nmi_i,
    .cpu_clk_en_o, .cpu_clk_sel_o, .periph_clk_en_o, .converter_clk_en_o, .indep_clk_en_o, .protected_clk_en_o,
    .power_state_o, .irq_o);

// *** design/lpw_pkg.sv ***
// Package of offsets, fields, reset values and timing for the wake controller
package lpw_pkg;
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] OFS_STATE = 8'h04;
    localparam logic [ADR_W-1:0] OFS_IIO0 = 8'h08;
    localparam logic [ADR_W-1:0] OFS_IIO1 = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_IIO2 = 8'h10;
    localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [ADR_W-1:0] OFS_IRQ_CLR = 8'h18;
    localparam logic [ADR_W-1:0] OFS_IRQ_EN = 8'h1C;
    // Control register fields
    localparam int CTRL_CLK_STOP_BIT = 0;
    localparam int CTRL_LVD_EN_BIT = 1;
    localparam int CTRL_STOP_REQ_BIT = 2;
    localparam int CTRL_ASSIGN_LSB = 4;
    localparam logic [2:0] CTRL_ASSIGN_RST = 3'h0;
    // State register fields
    localparam int STATE_MODE_LSB = 0;
    localparam int STATE_LVD_OK_BIT = 3;
    localparam int STATE_CLK_SEL_LSB = 4;
    // Request register fields
    localparam int IIO_FIXED_BIT = 0;
    localparam int IIO_FLAG_BIT = 1;
    // Interrupt status bits
    localparam int IRQ_WAIT_EXIT = 0;
    localparam int IRQ_STOP_EXIT = 1;
    localparam int IRQ_EXT_FLAG = 2;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
    // Detector start-up time and its cycle count at 25 MHz
    localparam int CLK_MHZ = 25;
    localparam int LVD_START_NS = 20000;
    localparam int LVD_START_CYC = (LVD_START_NS * CLK_MHZ + 999) / 1000;
    localparam int LVD_CNT_W = $clog2(LVD_START_CYC + 1);
    typedef enum logic [2:0] {
        PM_RUN = 3'b001,
        PM_WAIT = 3'b010,
        PM_STOP = 3'b100
    } lpw_mode_t;
endpackage : lpw_pkg

// *** design/lpw_wake_ctrl.sv ***
// Power mode sequencer with wake source selection and external request flags
`timescale 1ns/100ps

module lpw_wake_ctrl #(
    parameter int N_PERIPH = 64,
    parameter int LVD_CYC = lpw_pkg::LVD_START_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lpw_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic wait_exec_i,
    input wire logic [1:0] cpu_clk_sel_i,
    input wire logic nmi_i,
    input wire logic lvd_event_i,
    input wire logic [N_PERIPH-1:0] periph_irq_i,
    input wire logic [N_PERIPH-1:0] periph_indep_clk_i,
    input wire logic [2:0] ext_int_pin_i,
    output logic cpu_clk_en_o,
    output logic [1:0] cpu_clk_sel_o,
    output logic periph_clk_en_o,
    output logic converter_clk_en_o,
    output logic indep_clk_en_o,
    output logic protected_clk_en_o,
    output logic lvd_active_o,
    output logic [2:0] power_state_o,
    output logic irq_o
);
    import lpw_pkg::*;

    if (N_PERIPH < 1 || N_PERIPH > 64) begin : g_bad_periph
        $error("N_PERIPH must be 1 to 64");
    end
    if (LVD_CYC < 1 || LVD_CYC >= (1 << LVD_CNT_W)) begin : g_bad_lvd
        $error("LVD_CYC out of counter range");
    end

    // Registers
    lpw_mode_t mode_reg, mode_next;
    logic clk_stop_reg;
    logic lvd_en_reg;
    logic stop_req_reg;
    logic [2:0] assign_reg;
    logic [2:0] flag_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_en_reg;
    logic [LVD_CNT_W-1:0] lvd_cnt_reg;
    logic lvd_ok_reg;
    logic [1:0] clk_sel_reg;
    logic ack_reg;
    logic lvd_sync1_reg;
    logic lvd_sync2_reg;
    logic lvd_sync3_reg;
    logic [2:0] sync1_reg, sync2_reg, sync3_reg, pin_state_reg;

    // Address decode
    wire hit_ctrl = (wb_adr_i == OFS_CTRL);
    wire hit_state = (wb_adr_i == OFS_STATE);
    wire hit_iio0 = (wb_adr_i == OFS_IIO0);
    wire hit_iio1 = (wb_adr_i == OFS_IIO1);
    wire hit_iio2 = (wb_adr_i == OFS_IIO2);
    wire hit_stat = (wb_adr_i == OFS_IRQ_STAT);
    wire hit_clr = (wb_adr_i == OFS_IRQ_CLR);
    wire hit_en = (wb_adr_i == OFS_IRQ_EN);

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire wr_ctrl = bus_wr & hit_ctrl;
    wire wr_clr = bus_wr & hit_clr;
    wire wr_en = bus_wr & hit_en;
    wire [2:0] wr_iio;
    assign wr_iio[0] = bus_wr & hit_iio0;
    assign wr_iio[1] = bus_wr & hit_iio1;
    assign wr_iio[2] = bus_wr & hit_iio2;

    function automatic logic [31:0] iio_word(input logic flag);
        iio_word = 32'h0;
        iio_word[IIO_FIXED_BIT] = 1'b1;
        iio_word[IIO_FLAG_BIT] = flag;
    endfunction : iio_word

    wire [31:0] ctrl_word = {24'h0, 1'b0, assign_reg, 1'b0, stop_req_reg, lvd_en_reg, clk_stop_reg};
    wire [31:0] state_word = {26'h0, clk_sel_reg, lvd_ok_reg, mode_reg};
    wire [31:0] rdata_next =
        hit_ctrl ? ctrl_word :
        hit_state ? state_word :
        hit_iio0 ? iio_word(flag_reg[0]) :
        hit_iio1 ? iio_word(flag_reg[1]) :
        hit_iio2 ? iio_word(flag_reg[2]) :
        hit_stat ? {29'h0, irq_stat_reg} :
        hit_en ? {29'h0, irq_en_reg} : 32'h0;

    // External input synchronisers, falling edge once stage two and three agree
    wire [2:0] pin_agree = ~(sync2_reg ^ sync3_reg);
    wire [2:0] pin_fall = pin_agree & pin_state_reg & ~sync3_reg;
    wire [2:0] flag_set = pin_fall & assign_reg;
    logic [2:0] flag_clr;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            flag_clr[i] = wr_iio[i] & ~wb_dat_i[IIO_FLAG_BIT];
        end
    end
    wire [2:0] flag_next = flag_set | (flag_reg & ~flag_clr);

    // Wake sources
    wire [N_PERIPH-1:0] wait_mask = clk_stop_reg ? periph_indep_clk_i : {N_PERIPH{1'b1}};
    wire periph_wake_wait = |(periph_irq_i & wait_mask);
    wire ext_wake = |(flag_reg & assign_reg);
    wire wake_wait = nmi_i | periph_wake_wait | ext_wake;
    // Detector event counts once stages two and three agree high
    wire lvd_seen = lvd_sync2_reg & lvd_sync3_reg;
    wire lvd_wake = lvd_en_reg & lvd_ok_reg & lvd_seen;
    wire wake_stop = nmi_i | lvd_wake | (|periph_irq_i) | ext_wake;
    wire stop_enter = wr_ctrl & wb_dat_i[CTRL_STOP_REQ_BIT];

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            PM_RUN: begin
                if (stop_enter) begin
                    mode_next = PM_STOP;
                end else if (wait_exec_i) begin
                    mode_next = PM_WAIT;
                end
            end
            PM_WAIT: begin
                if (wake_wait) begin
                    mode_next = PM_RUN;
                end
            end
            PM_STOP: begin
                if (wake_stop) begin
                    mode_next = PM_RUN;
                end
            end
            default: mode_next = PM_RUN;
        endcase
    end

    wire next_run = (mode_next == PM_RUN);
    wire next_wait = (mode_next == PM_WAIT);
    wire next_stop = (mode_next == PM_STOP);
    wire periph_run_next = next_run | (next_wait & ~clk_stop_reg);
    wire [IRQ_W-1:0] irq_event;
    assign irq_event[IRQ_WAIT_EXIT] = (mode_reg == PM_WAIT) & next_run;
    assign irq_event[IRQ_STOP_EXIT] = (mode_reg == PM_STOP) & next_run;
    assign irq_event[IRQ_EXT_FLAG] = |flag_set;
    wire [IRQ_W-1:0] irq_clr = wr_clr ? wb_dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}};
    wire [IRQ_W-1:0] irq_stat_next = irq_event | (irq_stat_reg & ~irq_clr);
    wire lvd_done = (lvd_cnt_reg == LVD_CNT_W'(LVD_CYC));

    // Mode and clock gating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= PM_RUN;
            cpu_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            converter_clk_en_o <= 1'b1;
            indep_clk_en_o <= 1'b1;
            protected_clk_en_o <= 1'b1;
            power_state_o <= PM_RUN;
        end else begin
            mode_reg <= mode_next;
            cpu_clk_en_o <= next_run;
            periph_clk_en_o <= periph_run_next;
            converter_clk_en_o <= periph_run_next;
            indep_clk_en_o <= ~next_stop;
            protected_clk_en_o <= 1'b1;
            power_state_o <= mode_next;
        end
    end

    // CPU clock select frozen outside normal mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sel_reg <= 2'h0;
            cpu_clk_sel_o <= 2'h0;
        end else if (mode_reg == PM_RUN) begin
            clk_sel_reg <= cpu_clk_sel_i;
            cpu_clk_sel_o <= cpu_clk_sel_i;
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_stop_reg <= 1'b0;
            lvd_en_reg <= 1'b0;
            stop_req_reg <= 1'b0;
            assign_reg <= CTRL_ASSIGN_RST;
        end else begin
            stop_req_reg <= stop_enter & (mode_reg == PM_RUN);
            if (wr_ctrl) begin
                clk_stop_reg <= wb_dat_i[CTRL_CLK_STOP_BIT];
                lvd_en_reg <= wb_dat_i[CTRL_LVD_EN_BIT];
                assign_reg <= wb_dat_i[CTRL_ASSIGN_LSB +: 3];
            end
        end
    end

    // Detector start-up timer
    always_ff @(posedge clk_i) begin
        if (rst_i || !lvd_en_reg) begin
            lvd_cnt_reg <= '0;
            lvd_ok_reg <= 1'b0;
            lvd_active_o <= 1'b0;
        end else begin
            lvd_active_o <= 1'b1;
            if (lvd_done) begin
                lvd_ok_reg <= 1'b1;
            end else begin
                lvd_cnt_reg <= lvd_cnt_reg + LVD_CNT_W'(1);
            end
        end
    end

    // Detector event synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvd_sync1_reg <= 1'b0;
            lvd_sync2_reg <= 1'b0;
            lvd_sync3_reg <= 1'b0;
        end else begin
            lvd_sync1_reg <= lvd_event_i;
            lvd_sync2_reg <= lvd_sync1_reg;
            lvd_sync3_reg <= lvd_sync2_reg;
        end
    end

    // Pin sampling and request flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            sync3_reg <= 3'h7;
            pin_state_reg <= 3'h7;
            flag_reg <= 3'h0;
        end else begin
            sync1_reg <= ext_int_pin_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 3; i++) begin
                if (pin_agree[i]) begin
                    pin_state_reg[i] <= sync3_reg[i];
                end
            end
            flag_reg <= flag_next;
        end
    end

    // Interrupt status, enable and output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
            irq_en_reg <= IRQ_EN_RST;
            irq_o <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_en) begin
                irq_en_reg <= wb_dat_i[IRQ_W-1:0];
            end
            irq_o <= |(irq_stat_next & (wr_en ? wb_dat_i[IRQ_W-1:0] : irq_en_reg));
        end
    end

    // Bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_reg <= bus_req;
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rdata_next : 32'h0;
        end
    end
endmodule : lpw_wake_ctrl
